// File: src/olsm_top.sv
// Notes on behaviour
// - High ratio: continuous open-load check while on
// - Open load: fault pin low, bit set, stay on
// - Fault pin returns high; bit stays set
// - High ratio, off read clears bit
// - High ratio, on read clears if cause gone
// - Low ratio: periodic checks, fast slew only
// - Internal PWM low ratio: check every 150 ms
// - Check at first turn-off after 150 ms
// - Direct input low ratio: check each turn-off
// - Direct low ratio: clear after clean check read
// - Sense select bits route channel or temperature
// - Overcurrent window: sensing off, valid pin high
// - Track-hold bit 0: synchronous, nothing after off
// - Track-hold bit 1: hold value after turn-off
// - Valid pin low after settling until switch-off
// - Ratio bit picks ratio, lowers overcurrent threshold
// - Disable bits stop each detection individually
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
module olsm_top
    import olsm_pkg::*;
#(
    parameter int OLED_CYCLES = olsm_pkg::OLSM_OLED_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic channel_on_in,
    input wire logic pwm_on_in,
    input wire logic load_low_in,
    input wire logic out_high_off_in,
    input wire logic oc_window_in,
    output logic channel_on,
    output logic fault_status_out_n,
    output logic sense_valid_n,
    output logic [1:0] sense_route,
    output logic sense_hold,
    output logic sense_enable,
    output logic low_ratio_sel,
    output logic os_check_en,
    output logic oloff_check_en
);
    import olsm_pkg::*;

    // ********************************
    // Pin synchronisers
    // ********************************
    logic in_s, pwm_s, low_s, offh_s, oc_s;
    olsm_sync u_s0 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .din(channel_on_in),
        .dout(in_s));
    olsm_sync u_s1 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .din(pwm_on_in),
        .dout(pwm_s));
    olsm_sync u_s2 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .din(load_low_in),
        .dout(low_s));
    olsm_sync u_s3 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .din(out_high_off_in),
        .dout(offh_s));
    olsm_sync u_s4 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .din(oc_window_in),
        .dout(oc_s));

    // ********************************
    // Registers
    // ********************************
    logic [8:0] cc_r;
    logic [2:0] gc_r;
    logic oc_r;
    logic open_load_on_fault_r, oloff_r, os_r;
    logic ack_r;
    logic on_d_r;
    logic [31:0] tmr_r;
    logic armed_r;
    logic clean_r;
    logic off_seen_r;
    olsm_sv_t sv_r;
    logic [7:0] settle_r;

    // ********************************
    // Decode
    // ********************************
    wire access = (avs_read | avs_write) & clk_en;
    wire wr_go = avs_write & ack_r & clk_en;
    wire rd_go = avs_read & ack_r & clk_en;
    wire fault_rd = rd_go & (avs_address == OLSM_ADDR_FAULT);
    wire sel_cc = avs_address == OLSM_ADDR_CHAN_CFG;
    wire sel_gc = avs_address == OLSM_ADDR_GEN_CFG;
    wire sel_oc = avs_address == OLSM_ADDR_OC_CFG;
    wire low_mode = oc_r;
    wire dir_dis = cc_r[OLSM_CC_DIR_DIS];
    wire use_pwm = cc_r[OLSM_CC_PWM_EN] | dir_dis;
    wire open_load_on_disable = cc_r[OLSM_CC_OPEN_LOAD_ON_DISABLE];
    wire on_now = use_pwm ? pwm_s : in_s;
    wire turn_off = on_d_r & ~on_now;
    wire turn_on = ~on_d_r & on_now;
    wire fast = cc_r[OLSM_CC_FAST_SLEW];

    // High ratio: continuous compare while on
    wire hi_det = ~low_mode & on_now & low_s & ~open_load_on_disable;
    // Low ratio periodic event, fast slew only
    // Internal source held fully on still gets its periodic
    wire pwm_evt = armed_r & (turn_off | (on_now & ~off_seen_r));
    wire lo_evt = low_mode & fast & ~open_load_on_disable & (use_pwm ? pwm_evt : turn_off);
    wire lo_det = lo_evt & low_s;
    wire os_det = ~on_now & offh_s & ~cc_r[OLSM_CC_OS_DIS];
    wire oloff_det = ~on_now & offh_s & ~cc_r[OLSM_CC_OLOFF_DIS];

    // Clear conditions; a fresh detection wins over the clear
    wire clr_hi = ~low_mode & (~on_now | ~low_s);
    wire clr_lo = low_mode & (use_pwm ? ~low_s : clean_r);
    wire open_load_on_fault_clr = fault_rd & (clr_hi | clr_lo);
    wire open_load_on_fault_set = hi_det | lo_det;

    assign avs_waitrequest = access & ~ack_r;

    // ********************************
    // Bus and configuration
    // ********************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            cc_r <= OLSM_CHAN_CFG_RST;
            gc_r <= OLSM_GEN_CFG_RST;
            oc_r <= OLSM_OC_CFG_RST;
            avs_readdata <= 32'h0;
        end else if (clk_en) begin
            ack_r <= access & ~ack_r;
            if (wr_go & sel_cc & avs_byteenable[0])
                cc_r[7:0] <= avs_writedata[7:0];
            if (wr_go & sel_cc & avs_byteenable[1])
                cc_r[8] <= avs_writedata[8];
            if (wr_go & sel_gc & avs_byteenable[0])
                gc_r <= avs_writedata[2:0];
            if (wr_go & sel_oc & avs_byteenable[0])
                oc_r <= avs_writedata[0];
            if (access & ~ack_r & avs_read) begin
                case (avs_address)
                    OLSM_ADDR_CHAN_CFG: avs_readdata <= {23'h0, cc_r};
                    OLSM_ADDR_GEN_CFG: avs_readdata <= {29'h0, gc_r};
                    OLSM_ADDR_OC_CFG: avs_readdata <= {31'h0, oc_r};
                    OLSM_ADDR_FAULT: avs_readdata <= {28'h0, on_now, os_r, oloff_r, open_load_on_fault_r};
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ********************************
    // Fault bits and periodic timer
    // ********************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            open_load_on_fault_r <= 1'b0;
            oloff_r <= 1'b0;
            os_r <= 1'b0;
            on_d_r <= 1'b0;
            tmr_r <= 32'h0;
            armed_r <= 1'b0;
            clean_r <= 1'b0;
            off_seen_r <= 1'b0;
        end else if (clk_en) begin
            on_d_r <= on_now;
            // No turn-off since the last check means full duty
            if (lo_evt)
                off_seen_r <= 1'b0;
            else if (turn_off)
                off_seen_r <= 1'b1;
            if (open_load_on_fault_set)
                open_load_on_fault_r <= 1'b1;
            else if (open_load_on_fault_clr)
                open_load_on_fault_r <= 1'b0;
            if (oloff_det)
                oloff_r <= 1'b1;
            else if (fault_rd)
                oloff_r <= 1'b0;
            if (os_det)
                os_r <= 1'b1;
            else if (fault_rd)
                os_r <= 1'b0;
            if (lo_evt)
                clean_r <= ~low_s;
            else if (fault_rd)
                clean_r <= 1'b0;
            if (lo_evt) begin
                tmr_r <= 32'h0;
                armed_r <= 1'b0;
            end else if (tmr_r >= 32'(OLED_CYCLES - 1)) begin
                armed_r <= 1'b1;
            end else begin
                tmr_r <= tmr_r + 32'h1;
            end
        end
    end

    // ********************************
    // Sense valid sequencing
    // ********************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sv_r <= OLSM_SV_IDLE;
            settle_r <= 8'h0;
        end else if (clk_en) begin
            case (sv_r)
                OLSM_SV_IDLE: begin
                    settle_r <= 8'h0;
                    if (turn_on)
                        sv_r <= OLSM_SV_SETTLE;
                end
                OLSM_SV_SETTLE: begin
                    if (~on_now)
                        sv_r <= OLSM_SV_IDLE;
                    else if (settle_r >= 8'(OLSM_SETTLE_CYCLES - 1))
                        sv_r <= OLSM_SV_VALID;
                    else
                        settle_r <= settle_r + 8'h1;
                end
                OLSM_SV_VALID: begin
                    if (~on_now)
                        sv_r <= OLSM_SV_IDLE;
                end
                default: sv_r <= OLSM_SV_IDLE;
            endcase
        end
    end

    // ********************************
    // Outputs
    // ********************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_status_out_n <= 1'b1;
            sense_valid_n <= 1'b1;
            sense_enable <= 1'b0;
            sense_route <= 2'h0;
            sense_hold <= 1'b0;
            channel_on <= 1'b0;
            low_ratio_sel <= 1'b0;
            os_check_en <= 1'b0;
            oloff_check_en <= 1'b0;
        end else if (clk_en) begin
            // Real-time cause, not the latched bit, drives the pin
            fault_status_out_n <= ~(hi_det | lo_det | os_det | oloff_det);
            sense_valid_n <= ~((sv_r == OLSM_SV_VALID) & on_now & ~oc_s);
            sense_route <= {gc_r[OLSM_GC_SEL1], gc_r[OLSM_GC_SEL0]};
            // Track-hold keeps the output alive after off
            sense_enable <= ~oc_s & (on_now | gc_r[OLSM_GC_TH_EN]);
            sense_hold <= gc_r[OLSM_GC_TH_EN] & ~on_now;
            channel_on <= on_now; // Open load never turns the channel off
            low_ratio_sel <= low_mode;
            os_check_en <= ~cc_r[OLSM_CC_OS_DIS];
            oloff_check_en <= ~cc_r[OLSM_CC_OLOFF_DIS];
        end
    end
endmodule // olsm_top

// File: include/olsm_pkg.sv
package olsm_pkg;

    // ********************************
    // Register map (word byte addresses)
    // ********************************
    localparam logic [3:0] OLSM_ADDR_CHAN_CFG = 4'h0;
    localparam logic [3:0] OLSM_ADDR_GEN_CFG = 4'h4;
    localparam logic [3:0] OLSM_ADDR_OC_CFG = 4'h8;
    localparam logic [3:0] OLSM_ADDR_FAULT = 4'hc;
    localparam logic [3:0] OLSM_ADDR_STATUS = 4'h0;

    // ********************************
    // Field positions
    // ********************************
    localparam int OLSM_CC_DIR_DIS = 5;
    localparam int OLSM_CC_OS_DIS = 6;
    localparam int OLSM_CC_OLOFF_DIS = 7;
    localparam int OLSM_CC_OPEN_LOAD_ON_DISABLE = 8;
    localparam int OLSM_CC_PWM_EN = 0;
    localparam int OLSM_CC_FAST_SLEW = 1;
    localparam int OLSM_GC_SEL0 = 0;
    localparam int OLSM_GC_SEL1 = 1;
    localparam int OLSM_GC_TH_EN = 2;
    localparam int OLSM_OC_RATIO = 0;
    localparam int OLSM_FR_OPEN_LOAD_ON_FAULT = 0;
    localparam int OLSM_FR_OLOFF = 1;
    localparam int OLSM_FR_OS = 2;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [8:0] OLSM_CHAN_CFG_RST = 9'h000;
    localparam logic [2:0] OLSM_GEN_CFG_RST = 3'h0;
    localparam logic OLSM_OC_CFG_RST = 1'b0;

    // ********************************
    // Timing
    // ********************************
    localparam int OLSM_CLK_HZ = 10_000_000;
    localparam int OLSM_OLED_PERIOD_MS = 150;
    localparam int OLSM_OLED_CYCLES = OLSM_CLK_HZ / 1000 * OLSM_OLED_PERIOD_MS;
    localparam int OLSM_SETTLE_NS = 2000;
    localparam int OLSM_SETTLE_CYCLES = (OLSM_SETTLE_NS + 99) / 100;

    // ********************************
    // Sense routing
    // ********************************
    typedef enum logic [1:0] {
        OLSM_SNS_OFF = 2'b00,
        OLSM_SNS_CH0 = 2'b01,
        OLSM_SNS_CH1 = 2'b10,
        OLSM_SNS_TEMP = 2'b11
    } olsm_sns_t;

    typedef enum logic [1:0] {
        OLSM_SV_IDLE = 2'b00,
        OLSM_SV_SETTLE = 2'b01,
        OLSM_SV_VALID = 2'b10
    } olsm_sv_t;

endpackage

// File: src/olsm_sync.sv
module olsm_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    // ********************************
    // Two-stage synchroniser
    // ********************************
    logic meta_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else if (clk_en) begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // olsm_sync

// File: verification/olsm_load_model.sv
// ****
// Load and comparator model
// ****
module olsm_load_model (
    input wire logic channel_on,
    input wire logic open_cmd,
    output logic load_low_in,
    output logic out_high_off_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open wire: current stays low however the switch is set
    assign load_low_in = open_cmd;
    // Injected off current lifts an unloaded output above threshold
    assign out_high_off_in = !channel_on && open_cmd;
endmodule // olsm_load_model

// File: verification/olsm_monitor.sv
module olsm_monitor
    import olsm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic load_low_in,
    input wire logic out_high_off_in,
    input wire logic oc_window_in,
    input wire logic channel_on,
    input wire logic fault_status_out_n,
    input wire logic sense_valid_n,
    input wire logic [1:0] sense_route,
    input wire logic sense_enable,
    input wire logic low_ratio_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Pins reach outputs three edges late
    // ****
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_wait_one: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait state");
    a_reset_idle: assert property (disable iff (1'b0) !rst_n |=>
        fault_status_out_n && sense_valid_n && !channel_on) else $error("bad reset state");
    a_fault_cause: assert property ($fell(fault_status_out_n) |->
        $past(load_low_in, 3) || $past(out_high_off_in, 3)) else $error("fault no cause");
    a_fault_clear: assert property (
        (!low_ratio_sel && !load_low_in && !out_high_off_in) [*4] |-> fault_status_out_n)
        else $error("fault pin stuck");
    a_valid_off: assert property ((!channel_on) [*3] |-> sense_valid_n)
        else $error("valid while off");
    a_oc_blind: assert property (oc_window_in [*4] |-> sense_valid_n && !sense_enable)
        else $error("sensing in window");
    a_route_write: assert property ($changed(sense_route) |-> $past(avs_write, 2) &&
        $past(avs_address, 2) == OLSM_ADDR_GEN_CFG) else $error("route moved");
    a_ratio_write: assert property ($changed(low_ratio_sel) |-> $past(avs_write, 2) &&
        $past(avs_address, 2) == OLSM_ADDR_OC_CFG) else $error("ratio moved");
    c_fault: cover property ($fell(fault_status_out_n));
    c_valid: cover property ($fell(sense_valid_n));
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule // olsm_monitor

bind olsm_top olsm_monitor olsm_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .load_low_in(load_low_in),
    .out_high_off_in(out_high_off_in), .oc_window_in(oc_window_in), .channel_on(channel_on),
    .fault_status_out_n(fault_status_out_n), .sense_valid_n(sense_valid_n),
    .sense_route(sense_route), .sense_enable(sense_enable), .low_ratio_sel(low_ratio_sel));

// File: verification/olsm_tb_top.sv
module olsm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import olsm_pkg::*;
    // Short check period keeps the run brief
    localparam int OLED = 50;
    localparam logic [3:0] FR = OLSM_ADDR_FAULT;
    logic rst_n = 1'b0, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0, open_cmd = 1'b0;
    logic channel_on_in = 1'b0, pwm_on_in = 1'b0, oc_window_in = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic sys_clk, avs_waitrequest, load_low_in, out_high_off_in, channel_on, sense_valid_n;
    logic fault_status_out_n, sense_hold, sense_enable, low_ratio_sel, os_check_en;
    logic oloff_check_en;
    logic [1:0] sense_route;
    int fail_count, n_tests, cyc, k;

    olsm_top #(.OLED_CYCLES(OLED)) olsm_top_inst (.sys_clk, .rst_n, .clk_en, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .channel_on_in, .pwm_on_in, .load_low_in, .out_high_off_in, .oc_window_in, .channel_on,
        .fault_status_out_n, .sense_valid_n, .sense_route, .sense_hold, .sense_enable,
        .low_ratio_sel, .os_check_en, .oloff_check_en);
    olsm_load_model olsm_load_model_inst (.channel_on, .open_cmd, .load_low_in,
        .out_high_off_in);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdr(input logic [3:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        rdr(a);
        chk(rd & m, e);
    endtask
    task automatic pulse();
        channel_on_in <= 1'b1;
        tick(20);
        channel_on_in <= 1'b0;
        tick(6);
    endtask

    initial begin
        tick(16);
        rst_n <= 1'b1;
        tick(1);
        for (int i = 0; i < 4; i++) rdc(4'(i * 4), '1, 0);
        wr(4'h2, '1);
        rdc(4'h2, '1, 0);
        wr(FR, '1);
        rdc(FR, '1, 0);
        for (int i = 0; i < 4; i++) begin
            wr(OLSM_ADDR_GEN_CFG, i);
            tick(1);
            chk(sense_route, i);
        end
        wr(OLSM_ADDR_OC_CFG, 1);
        tick(1);
        chk(low_ratio_sel, 1);
        wr(OLSM_ADDR_OC_CFG, 0);
        for (int th = 0; th < 2; th++) begin
            wr(OLSM_ADDR_GEN_CFG, th * 4);
            channel_on_in <= 1'b1;
            tick(30);
            chk(sense_valid_n, 0);
            oc_window_in <= 1'b1;
            tick(5);
            chk({sense_valid_n, sense_enable}, 2'b10);
            oc_window_in <= 1'b0;
            tick(30);
            channel_on_in <= 1'b0;
            tick(5);
            chk({sense_valid_n, sense_hold}, {1'b1, th[0]});
        end
        open_cmd <= 1'b1;
        channel_on_in <= 1'b1;
        tick(10);
        chk({fault_status_out_n, channel_on}, 2'b01);
        rdc(FR, 32'h9, 32'h9);
        rdc(FR, 1, 1);
        open_cmd <= 1'b0;
        tick(6);
        chk(fault_status_out_n, 1);
        rdc(FR, 1, 1);
        rdc(FR, 1, 0);
        open_cmd <= 1'b1;
        tick(6);
        channel_on_in <= 1'b0;
        tick(6);
        rdc(FR, 1, 1);
        rdc(FR, 1, 0);
        wr(OLSM_ADDR_CHAN_CFG, 32'hc0); // Off-state checks held off by the controller
        tick(1);
        chk({os_check_en, oloff_check_en}, 0);
        wr(OLSM_ADDR_CHAN_CFG, 32'h100);
        tick(1);
        chk({os_check_en, oloff_check_en}, 3);
        channel_on_in <= 1'b1;
        tick(10);
        rdc(FR, 1, 0);
        channel_on_in <= 1'b0;
        wr(OLSM_ADDR_CHAN_CFG, 0);
        wr(OLSM_ADDR_OC_CFG, 1);
        pulse();
        rdc(FR, 1, 0);
        wr(OLSM_ADDR_CHAN_CFG, 2);
        channel_on_in <= 1'b1;
        tick(20);
        rdc(FR, 1, 0);
        channel_on_in <= 1'b0;
        tick(6);
        rdc(FR, 1, 1);
        rdc(FR, 1, 1);
        open_cmd <= 1'b0;
        pulse();
        rdc(FR, 1, 1);
        rdc(FR, 1, 0);
        // Internal source at full duty still gets checked
        wr(OLSM_ADDR_CHAN_CFG, 32'h23);
        pwm_on_in <= 1'b1;
        open_cmd <= 1'b1;
        k = 0;
        while (fault_status_out_n !== 1'b0 && k < 3 * OLED) begin
            tick(1);
            k++;
        end
        chk(k < 3 * OLED, 1);
        open_cmd <= 1'b0;
        tick(3);
        rdr(FR);
        open_cmd <= 1'b1;
        k = 6;
        do begin
            rdr(FR);
            k += 3;
        end while (rd[0] !== 1'b1 && k < 3 * OLED);
        chk(k >= OLED - 6 && k <= OLED + 6, 1);
        finish_test();
    end
endmodule // olsm_tb_top
